// ===== core/aq_map.svh
`ifndef AQ_MAP_SVH
`define AQ_MAP_SVH

`define AQ_ADDR_W            8
`define AQ_DATA_W            32
`define AQ_TXQ_W             33
`define AQ_LAST_BIT          32
`define AQ_TXQ_DEPTH         16
`define AQ_TXQ_PTR_W         4
`define AQ_TXQ_CNT_W         5
`define AQ_TXQ_FULL_CNT      5'h10
`define AQ_TXQ_PTR_ONE       4'h1
`define AQ_SKID_DEPTH        2
`define AQ_SKID_CNT_W        2
`define AQ_SKID_FULL_CNT     2'h2
`define AQ_NUM_Q             2
`define AQ_REQ               1'h0
`define AQ_RSP               1'h1

`define AQ_OFS_TX_REQ_MID    8'h88
`define AQ_OFS_TX_REQ_FINAL  8'h8C
`define AQ_OFS_TX_RSP_MID    8'h90
`define AQ_OFS_TX_RSP_FINAL  8'h94
`define AQ_OFS_RX_REQ        8'h98
`define AQ_OFS_RX_RSP        8'h9C
`define AQ_OFS_IRQ_ACK       8'hA0

`define AQ_RDATA_RESET       32'h0000_0000

`endif

// ===== core/aq_pkg.sv
package aq_pkg;
  `include "aq_map.svh"

  typedef struct packed {
    logic [`AQ_TXQ_DEPTH-1:0][`AQ_TXQ_W-1:0] mem;
    logic [`AQ_TXQ_PTR_W-1:0]                wr_ptr;
    logic [`AQ_TXQ_PTR_W-1:0]                rd_ptr;
    logic [`AQ_TXQ_CNT_W-1:0]                count;
    logic [`AQ_TXQ_W-1:0]                    out_data;
    logic                                    out_valid;
  } fifo_state_t;

  typedef struct packed {
    logic [`AQ_SKID_DEPTH-1:0][`AQ_DATA_W-1:0] slot;
    logic [`AQ_SKID_CNT_W-1:0]                 cnt;
  } skid_state_t;

  typedef struct packed {
    logic [`AQ_NUM_Q-1:0]                  hold_full;
    logic [`AQ_NUM_Q-1:0][`AQ_TXQ_W-1:0]   hold;
    logic [`AQ_NUM_Q-1:0]                  xfer_valid;
    logic [`AQ_NUM_Q-1:0][`AQ_DATA_W-1:0]  xfer;
    logic [`AQ_DATA_W-1:0]                 rdata;
  } host_state_t;
endpackage

// ===== core/async_queue_host_access.sv
// What this block does
// - A write to 0x088 queues a first or middle quadlet in the transmit request queue without closing the packet.
// - A write to 0x08C queues the final quadlet of a transmit request packet, completing it.
// - A write to 0x090 queues a first or middle quadlet in the transmit response queue.
// - A write to 0x094 queues the final quadlet of a transmit response packet, completing it.
// - A request write drops the request write-ready flag until the quadlet has moved into its queue.
// - A response write drops the response write-ready flag until the quadlet has moved into its queue.
// - A read of 0x098 returns the quadlet in the receive request transfer register.
// - That read drops the request quadlet-available flag until the next quadlet is loaded.
// - A read of 0x09C returns the quadlet in the receive response transfer register.
// - That read drops the response quadlet-available flag until the next quadlet is loaded.
// - The request queue idle status is high while its transfer register holds nothing pending.
`timescale 1ns/1ps
`include "aq_map.svh"
module async_queue_host_access
  import aq_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  ce_i,
  input  wire logic [`AQ_ADDR_W-1:0] reg_addr_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  input  wire logic [`AQ_DATA_W-1:0] reg_wdata_i,
  output logic [`AQ_DATA_W-1:0]      reg_rdata_o,
  output logic                       tx_req_write_ready_o,
  output logic                       tx_rsp_write_ready_o,
  output logic                       rx_req_quadlet_avail_o,
  output logic                       rx_rsp_quadlet_avail_o,
  output logic                       tx_req_queue_idle_o,
  output logic                       tx_rsp_queue_idle_o,
  output logic [`AQ_DATA_W-1:0]      tx_req_data_o,
  output logic                       tx_req_last_o,
  output logic                       tx_req_valid_o,
  input  wire logic                  tx_req_ready_i,
  output logic [`AQ_DATA_W-1:0]      tx_rsp_data_o,
  output logic                       tx_rsp_last_o,
  output logic                       tx_rsp_valid_o,
  input  wire logic                  tx_rsp_ready_i,
  input  wire logic [`AQ_DATA_W-1:0] rx_req_data_i,
  input  wire logic                  rx_req_valid_i,
  output logic                       rx_req_ready_o,
  input  wire logic [`AQ_DATA_W-1:0] rx_rsp_data_i,
  input  wire logic                  rx_rsp_valid_i,
  output logic                       rx_rsp_ready_o
);
  host_state_t                         s;
  host_state_t                         next_s;
  logic                                wr_hit;
  logic                                wr_q;
  logic                                wr_last;
  logic                                rd_hit;
  logic                                rd_q;
  logic [`AQ_NUM_Q-1:0]                txq_in_ready;
  logic [`AQ_NUM_Q-1:0][`AQ_TXQ_W-1:0] txq_out_data;
  logic [`AQ_NUM_Q-1:0]                skid_valid;
  logic [`AQ_NUM_Q-1:0][`AQ_DATA_W-1:0] skid_data;

  // Write decode picks queue and end-of-packet marker from the address
  always_comb begin
    wr_hit  = 1'b0;
    wr_q    = `AQ_REQ;
    wr_last = 1'b0;
    if (reg_addr_i == `AQ_OFS_TX_REQ_MID) begin
      wr_hit = reg_wr_i;
    end else if (reg_addr_i == `AQ_OFS_TX_REQ_FINAL) begin
      wr_hit  = reg_wr_i;
      wr_last = 1'b1;
    end else if (reg_addr_i == `AQ_OFS_TX_RSP_MID) begin
      wr_hit = reg_wr_i;
      wr_q   = `AQ_RSP;
    end else if (reg_addr_i == `AQ_OFS_TX_RSP_FINAL) begin
      wr_hit  = reg_wr_i;
      wr_q    = `AQ_RSP;
      wr_last = 1'b1;
    end
  end

  // Read decode; the acknowledge word is not modelled and reads as zero
  always_comb begin
    rd_hit = 1'b0;
    rd_q   = `AQ_REQ;
    if (reg_addr_i == `AQ_OFS_RX_REQ) begin
      rd_hit = reg_rd_i;
    end else if (reg_addr_i == `AQ_OFS_RX_RSP) begin
      rd_hit = reg_rd_i;
      rd_q   = `AQ_RSP;
    end
  end

  always_comb begin
    next_s = s;
    if (reg_rd_i) begin
      next_s.rdata = `AQ_RDATA_RESET;
    end
    for (int q = 0; q < `AQ_NUM_Q; q++) begin
      // Transfer register drains into the queue as soon as it has room
      if (s.hold_full[q] && txq_in_ready[q]) begin
        next_s.hold_full[q] = 1'b0;
      end
      // A write while busy is dropped, never overwrites the pending quadlet
      if (wr_hit && (wr_q == 1'(q)) && !s.hold_full[q]) begin
        next_s.hold[q]      = {wr_last, reg_wdata_i};
        next_s.hold_full[q] = 1'b1;
      end
      if (rd_hit && (rd_q == 1'(q))) begin
        next_s.rdata         = s.xfer[q];
        next_s.xfer_valid[q] = 1'b0;
      end else if (!s.xfer_valid[q] && skid_valid[q]) begin
        next_s.xfer[q]       = skid_data[q];
        next_s.xfer_valid[q] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign reg_rdata_o            = s.rdata;
  assign tx_req_write_ready_o   = !s.hold_full[`AQ_REQ];
  assign tx_rsp_write_ready_o   = !s.hold_full[`AQ_RSP];
  assign tx_req_queue_idle_o    = !s.hold_full[`AQ_REQ];
  assign tx_rsp_queue_idle_o    = !s.hold_full[`AQ_RSP];
  assign rx_req_quadlet_avail_o = s.xfer_valid[`AQ_REQ];
  assign rx_rsp_quadlet_avail_o = s.xfer_valid[`AQ_RSP];
  assign tx_req_data_o          = txq_out_data[`AQ_REQ][`AQ_DATA_W-1:0];
  assign tx_req_last_o          = txq_out_data[`AQ_REQ][`AQ_LAST_BIT];
  assign tx_rsp_data_o          = txq_out_data[`AQ_RSP][`AQ_DATA_W-1:0];
  assign tx_rsp_last_o          = txq_out_data[`AQ_RSP][`AQ_LAST_BIT];

  queue_fifo tx_req_queue (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .in_data_i   (s.hold[`AQ_REQ]),
    .in_valid_i  (s.hold_full[`AQ_REQ]),
    .in_ready_o  (txq_in_ready[`AQ_REQ]),
    .out_data_o  (txq_out_data[`AQ_REQ]),
    .out_valid_o (tx_req_valid_o),
    .out_ready_i (tx_req_ready_i)
  );

  queue_fifo tx_rsp_queue (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .in_data_i   (s.hold[`AQ_RSP]),
    .in_valid_i  (s.hold_full[`AQ_RSP]),
    .in_ready_o  (txq_in_ready[`AQ_RSP]),
    .out_data_o  (txq_out_data[`AQ_RSP]),
    .out_valid_o (tx_rsp_valid_o),
    .out_ready_i (tx_rsp_ready_i)
  );

  // Two-entry buffer lets the link keep streaming while the host is slow to read
  skid_pair rx_req_buffer (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .in_data_i   (rx_req_data_i),
    .in_valid_i  (rx_req_valid_i),
    .in_ready_o  (rx_req_ready_o),
    .out_data_o  (skid_data[`AQ_REQ]),
    .out_valid_o (skid_valid[`AQ_REQ]),
    .out_ready_i (!s.xfer_valid[`AQ_REQ])
  );

  skid_pair rx_rsp_buffer (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .in_data_i   (rx_rsp_data_i),
    .in_valid_i  (rx_rsp_valid_i),
    .in_ready_o  (rx_rsp_ready_o),
    .out_data_o  (skid_data[`AQ_RSP]),
    .out_valid_o (skid_valid[`AQ_RSP]),
    .out_ready_i (!s.xfer_valid[`AQ_RSP])
  );

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_req_write_taken;
    ce_i && reg_wr_i && tx_req_write_ready_o &&
      ((reg_addr_i == `AQ_OFS_TX_REQ_MID) || (reg_addr_i == `AQ_OFS_TX_REQ_FINAL));
  endsequence

  sequence s_rsp_write_taken;
    ce_i && reg_wr_i && tx_rsp_write_ready_o &&
      ((reg_addr_i == `AQ_OFS_TX_RSP_MID) || (reg_addr_i == `AQ_OFS_TX_RSP_FINAL));
  endsequence

  sequence s_req_moved;
    ce_i && txq_in_ready[`AQ_REQ];
  endsequence

  sequence s_rsp_moved;
    ce_i && txq_in_ready[`AQ_RSP];
  endsequence

  AST_TX_REQ_MID: assert property (
    (ce_i && reg_wr_i && tx_req_write_ready_o && (reg_addr_i == `AQ_OFS_TX_REQ_MID)) |=>
      (!s.hold[`AQ_REQ][`AQ_LAST_BIT] && (s.hold[`AQ_REQ][`AQ_DATA_W-1:0] == $past(reg_wdata_i))))
    else $error("request mid quadlet not captured");

  AST_TX_REQ_FINAL: assert property (
    (ce_i && reg_wr_i && tx_req_write_ready_o && (reg_addr_i == `AQ_OFS_TX_REQ_FINAL)) |=>
      (s.hold[`AQ_REQ][`AQ_LAST_BIT] && (s.hold[`AQ_REQ][`AQ_DATA_W-1:0] == $past(reg_wdata_i))))
    else $error("request final quadlet not marked last");

  AST_TX_RSP_MID: assert property (
    (ce_i && reg_wr_i && tx_rsp_write_ready_o && (reg_addr_i == `AQ_OFS_TX_RSP_MID)) |=>
      (!s.hold[`AQ_RSP][`AQ_LAST_BIT] && (s.hold[`AQ_RSP][`AQ_DATA_W-1:0] == $past(reg_wdata_i))))
    else $error("response mid quadlet not captured");

  AST_TX_RSP_FINAL: assert property (
    (ce_i && reg_wr_i && tx_rsp_write_ready_o && (reg_addr_i == `AQ_OFS_TX_RSP_FINAL)) |=>
      (s.hold[`AQ_RSP][`AQ_LAST_BIT] && (s.hold[`AQ_RSP][`AQ_DATA_W-1:0] == $past(reg_wdata_i))))
    else $error("response final quadlet not marked last");

  AST_TX_REQ_BUSY: assert property (
    s_req_write_taken |=> !tx_req_write_ready_o)
    else $error("request write-ready stayed high after a write");

  AST_TX_REQ_HOLD: assert property (
    (!tx_req_write_ready_o && !(ce_i && txq_in_ready[`AQ_REQ])) |=> !tx_req_write_ready_o)
    else $error("request write-ready rose before the quadlet moved");

  AST_TX_RSP_BUSY: assert property (
    s_rsp_write_taken ##1 !(ce_i && txq_in_ready[`AQ_RSP]) |=> !tx_rsp_write_ready_o)
    else $error("response write-ready rose before the quadlet moved");

  AST_TX_REQ_IDLE: assert property (
    s_req_write_taken ##1 s_req_moved |=> tx_req_queue_idle_o && tx_req_write_ready_o)
    else $error("request queue not idle after the transfer");

  AST_RX_REQ_READ: assert property (
    (ce_i && reg_rd_i && (reg_addr_i == `AQ_OFS_RX_REQ)) |=> (reg_rdata_o == $past(s.xfer[`AQ_REQ])))
    else $error("receive request read returned wrong quadlet");

  AST_RX_REQ_CLEAR: assert property (
    (ce_i && reg_rd_i && (reg_addr_i == `AQ_OFS_RX_REQ)) |=> !rx_req_quadlet_avail_o)
    else $error("request quadlet-available not cleared by read");

  AST_RX_REQ_RELOAD: assert property (
    (ce_i && !rx_req_quadlet_avail_o && skid_valid[`AQ_REQ]
      && !(reg_rd_i && (reg_addr_i == `AQ_OFS_RX_REQ))) |=>
      (rx_req_quadlet_avail_o && (s.xfer[`AQ_REQ] == $past(skid_data[`AQ_REQ]))))
    else $error("next request quadlet not loaded");

  AST_RX_RSP_READ: assert property (
    (ce_i && reg_rd_i && (reg_addr_i == `AQ_OFS_RX_RSP)) |=> (reg_rdata_o == $past(s.xfer[`AQ_RSP])))
    else $error("receive response read returned wrong quadlet");

  AST_RX_RSP_CLEAR: assert property (
    (ce_i && reg_rd_i && (reg_addr_i == `AQ_OFS_RX_RSP)) |=> !rx_rsp_quadlet_avail_o)
    else $error("response quadlet-available not cleared by read");

  AST_TX_REQ_DROP: assert property (
    (ce_i && reg_wr_i && !tx_req_write_ready_o && (reg_addr_i == `AQ_OFS_TX_REQ_MID)
      && !txq_in_ready[`AQ_REQ]) |=> $stable(s.hold[`AQ_REQ]))
    else $error("busy request transfer register was overwritten");

  AST_TX_RSP_HOLD: assert property (
    (!tx_rsp_write_ready_o && !(ce_i && txq_in_ready[`AQ_RSP])) |=> !tx_rsp_write_ready_o)
    else $error("response write-ready rose while the queue had no room");

  AST_TX_RSP_MOVED: assert property (
    s_rsp_write_taken ##1 s_rsp_moved |=> tx_rsp_write_ready_o && tx_rsp_queue_idle_o)
    else $error("response write-ready stayed low after the transfer");

  AST_TX_REQ_IDLE_LOW: assert property (
    s_req_write_taken |=> !tx_req_queue_idle_o)
    else $error("request queue idle while a quadlet is pending");

  AST_RX_RSP_RELOAD: assert property (
    (ce_i && !rx_rsp_quadlet_avail_o && skid_valid[`AQ_RSP]
      && !(reg_rd_i && (reg_addr_i == `AQ_OFS_RX_RSP))) |=>
      (rx_rsp_quadlet_avail_o && (s.xfer[`AQ_RSP] == $past(skid_data[`AQ_RSP]))))
    else $error("next response quadlet not loaded");

  AST_RX_REQ_HOLD: assert property (
    (rx_req_quadlet_avail_o && !(ce_i && reg_rd_i && (reg_addr_i == `AQ_OFS_RX_REQ)))
      |=> rx_req_quadlet_avail_o)
    else $error("request quadlet-available fell without a read");

  AST_RX_RSP_HOLD: assert property (
    (rx_rsp_quadlet_avail_o && !(ce_i && reg_rd_i && (reg_addr_i == `AQ_OFS_RX_RSP)))
      |=> rx_rsp_quadlet_avail_o)
    else $error("response quadlet-available fell without a read");

  AST_RD_OTHER_ZERO: assert property (
    (ce_i && reg_rd_i && (reg_addr_i != `AQ_OFS_RX_REQ) && (reg_addr_i != `AQ_OFS_RX_RSP)) |=>
      (reg_rdata_o == `AQ_RDATA_RESET))
    else $error("read of an unmapped place returned data");

  AST_RDATA_HOLD: assert property (
    (ce_i && !reg_rd_i) |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
endmodule

// ===== core/queue_fifo.sv
`timescale 1ns/1ps
`include "aq_map.svh"
module queue_fifo
  import aq_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  ce_i,
  input  wire logic [`AQ_TXQ_W-1:0]  in_data_i,
  input  wire logic                  in_valid_i,
  output logic                       in_ready_o,
  output logic [`AQ_TXQ_W-1:0]       out_data_o,
  output logic                       out_valid_o,
  input  wire logic                  out_ready_i
);
  fifo_state_t s;
  fifo_state_t next_s;
  logic        push;
  logic        load;

  assign in_ready_o  = (s.count != `AQ_TXQ_FULL_CNT);
  assign out_valid_o = s.out_valid;
  assign out_data_o  = s.out_data;
  assign push        = in_valid_i && in_ready_o;
  // Head is copied into a register so the read port is a flop
  assign load        = (s.count != '0) && (!s.out_valid || out_ready_i);

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr_ptr] = in_data_i;
      next_s.wr_ptr        = s.wr_ptr + `AQ_TXQ_PTR_ONE;
    end
    if (load) begin
      next_s.out_data  = s.mem[s.rd_ptr];
      next_s.rd_ptr    = s.rd_ptr + `AQ_TXQ_PTR_ONE;
      next_s.out_valid = 1'b1;
    end else if (out_ready_i) begin
      next_s.out_valid = 1'b0;
    end
    next_s.count = s.count + `AQ_TXQ_CNT_W'(push) - `AQ_TXQ_CNT_W'(load);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end
endmodule

// ===== core/skid_pair.sv
`timescale 1ns/1ps
`include "aq_map.svh"
module skid_pair
  import aq_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  ce_i,
  input  wire logic [`AQ_DATA_W-1:0] in_data_i,
  input  wire logic                  in_valid_i,
  output logic                       in_ready_o,
  output logic [`AQ_DATA_W-1:0]      out_data_o,
  output logic                       out_valid_o,
  input  wire logic                  out_ready_i
);
  skid_state_t s;
  skid_state_t next_s;
  logic        push;
  logic        pop;

  assign in_ready_o  = (s.cnt != `AQ_SKID_FULL_CNT);
  assign out_valid_o = (s.cnt != '0);
  assign out_data_o  = s.slot[`AQ_REQ];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    next_s = s;
    if (pop) begin
      next_s.slot[`AQ_REQ] = s.slot[`AQ_RSP];
      next_s.cnt           = s.cnt - `AQ_SKID_CNT_W'(1);
    end
    if (push) begin
      if (next_s.cnt == '0) begin
        next_s.slot[`AQ_REQ] = in_data_i;
      end else begin
        next_s.slot[`AQ_RSP] = in_data_i;
      end
      next_s.cnt = next_s.cnt + `AQ_SKID_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end
endmodule

// ===== verification/async_queue_host_access_bench.sv
`timescale 1ns/1ps
`include "aq_map.svh"
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); bad_count++; end end
module async_queue_host_access_bench;
  logic        ref_clk, rst_n, reg_wr, reg_rd, ok, ce;
  logic [7:0]  reg_addr, ofs, fin;
  logic [31:0] reg_wdata, reg_rdata, dv;
  logic [1:0]  wrdy, avail, idle, txv, txl, txr, rxv, rxr;
  logic [31:0] txd [2];
  logic [31:0] rxd [2];
  int          bad_count, n_checks, n;

  async_queue_host_access i_dut (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .ce_i(ce), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .tx_req_write_ready_o(wrdy[0]), .tx_rsp_write_ready_o(wrdy[1]),
    .rx_req_quadlet_avail_o(avail[0]), .rx_rsp_quadlet_avail_o(avail[1]),
    .tx_req_queue_idle_o(idle[0]), .tx_rsp_queue_idle_o(idle[1]),
    .tx_req_data_o(txd[0]), .tx_req_last_o(txl[0]), .tx_req_valid_o(txv[0]), .tx_req_ready_i(txr[0]),
    .tx_rsp_data_o(txd[1]), .tx_rsp_last_o(txl[1]), .tx_rsp_valid_o(txv[1]), .tx_rsp_ready_i(txr[1]),
    .rx_req_data_i(rxd[0]), .rx_req_valid_i(rxv[0]), .rx_req_ready_o(rxr[0]),
    .rx_rsp_data_i(rxd[1]), .rx_rsp_valid_i(rxv[1]), .rx_rsp_ready_o(rxr[1]));

  link_model i_link (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n),
    .tx_req_data_i(txd[0]), .tx_req_last_i(txl[0]), .tx_req_valid_i(txv[0]), .tx_req_ready_o(txr[0]),
    .tx_rsp_data_i(txd[1]), .tx_rsp_last_i(txl[1]), .tx_rsp_valid_i(txv[1]), .tx_rsp_ready_o(txr[1]),
    .rx_req_data_o(rxd[0]), .rx_req_valid_o(rxv[0]), .rx_req_ready_i(rxr[0]),
    .rx_rsp_data_o(rxd[1]), .rx_rsp_valid_o(rxv[1]), .rx_rsp_ready_i(rxr[1]));

  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task test_done;
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task hang(input string nm);
    $display("[ERR] %s exp 1 got 0", nm);
    bad_count++;
    test_done;
  endtask

  // Polls a flag at falling edges, bounded
  task automatic wait_flag(input bit rx, input bit sel, input int lim, output logic got);
    got = 1'h0;
    for (int i = 0; i < lim && !got; i++) begin
      @(negedge ref_clk);
      got = ((rx ? avail[sel] : wrdy[sel]) === 1'h1);
    end
  endtask

  // One-cycle strobe; returns at the falling edge after the taking edge
  task automatic strobe(input bit w, input logic [7:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge ref_clk);
    reg_wr = 1'h0;
    reg_rd = 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic g;
    wait_flag(1'h0, a[4], 100, g);
    if (!g) hang("write_ready");
    strobe(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input bit wait_av);
    logic g;
    g = 1'h1;
    if (wait_av) wait_flag(1'h1, a[2], 100, g);
    else @(negedge ref_clk);
    if (!g) hang("quadlet_avail");
    strobe(1'h0, a, 32'h0);
    `CHK("reg_rdata_o", ex, reg_rdata)
  endtask

  initial begin
    rst_n = 1'h0;
    ce = 1'h1;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (8) @(negedge ref_clk);
    rst_n = 1'h1;
    `CHK("write_ready", 2'h3, wrdy)
    `CHK("queue_idle", 2'h3, idle)
    `CHK("quadlet_avail", 2'h0, avail)
    `CHK("tx_valid", 2'h0, txv)
    `CHK("rx_ready", 2'h3, rxr)
    rd(`AQ_OFS_RX_REQ, 32'h0, 1'h0);
    rd(`AQ_OFS_RX_RSP, 32'h0, 1'h0);
    // Unmapped and write-only places have no effect and read zero
    @(negedge ref_clk);
    strobe(1'h1, `AQ_OFS_IRQ_ACK, 32'hFFFF_FFFF);
    `CHK("write_ready", 2'h3, wrdy)
    rd(`AQ_OFS_IRQ_ACK, 32'h0, 1'h0);
    rd(`AQ_OFS_TX_REQ_MID, 32'h0, 1'h0);
    // Mid then final quadlet on each transmit queue
    for (int q = 0; q < 2; q++) begin
      ofs = q ? `AQ_OFS_TX_RSP_MID : `AQ_OFS_TX_REQ_MID;
      fin = q ? `AQ_OFS_TX_RSP_FINAL : `AQ_OFS_TX_REQ_FINAL;
      dv = 32'hA000_0000 + 32'(q);
      wr(ofs, dv);
      `CHK("write_ready_low", 1'h0, wrdy[q])
      `CHK("idle_low", 1'h0, idle[q])
      wr(fin, ~dv);
      `CHK("write_ready_low", 1'h0, wrdy[q])
      wait_flag(1'h0, q[0], 20, ok);
      `CHK("idle_back", 1'h1, idle[q])
      repeat (6) @(negedge ref_clk);
      `CHK("tx_count", 2, i_link.got[q].size())
      `CHK("tx_mid", {1'h0, dv}, i_link.got[q][0])
      `CHK("tx_final", {1'h1, ~dv}, i_link.got[q][1])
      i_link.got[q].delete();
    end
    // Stalled link: fill the request queue until writes are refused
    i_link.stall = 1'h1;
    n = 0;
    for (int k = 0; k < 40; k++) begin
      wait_flag(1'h0, 1'h0, 20, ok);
      if (!ok) break;
      strobe(1'h1, (k[1:0] == 2'h3) ? `AQ_OFS_TX_REQ_FINAL : `AQ_OFS_TX_REQ_MID, 32'hC000_0000 + 32'(k));
      n++;
    end
    `CHK("full_write_ready", 1'h0, wrdy[0])
    `CHK("full_idle", 1'h0, idle[0])
    `CHK("fill_depth", 1'h1, n >= 16)
    strobe(1'h1, `AQ_OFS_TX_REQ_MID, 32'hDEAD_0000);
    i_link.stall = 1'h0;
    for (int i = 0; i < 400 && i_link.got[0].size() < n; i++) @(negedge ref_clk);
    repeat (6) @(negedge ref_clk);
    `CHK("drain_count", n, i_link.got[0].size())
    for (int k = 0; k < n; k++) begin
      `CHK("drain_order", {k[1:0] == 2'h3, 32'hC000_0000 + 32'(k)}, i_link.got[0][k])
    end
    `CHK("idle_after_drain", 1'h1, idle[0])
    // Receive: fill transfer register and buffer, then read them out in order
    for (int q = 0; q < 2; q++) begin
      ofs = q ? `AQ_OFS_RX_RSP : `AQ_OFS_RX_REQ;
      for (int j = 0; j < 3; j++) begin
        i_link.push(q[0], 32'hD000_0000 + 32'(q * 256 + j), ok);
        `CHK("rx_push", 1'h1, ok)
      end
      `CHK("rx_ready_full", 1'h0, rxr[q])
      for (int j = 0; j < 3; j++) begin
        rd(ofs, 32'hD000_0000 + 32'(q * 256 + j), 1'h1);
        `CHK("avail_drop", 1'h0, avail[q])
      end
      rd(ofs, 32'hD000_0002 + 32'(q * 256), 1'h0);
      `CHK("avail_stays_low", 1'h0, avail[q])
    end
    // Read data is nonzero here, so a zero proves the unmapped read
    rd(`AQ_OFS_IRQ_ACK, 32'h0, 1'h0);
    // Clock enable low freezes the block, so this write must leave no trace
    ce = 1'h0;
    @(negedge ref_clk);
    strobe(1'h1, `AQ_OFS_TX_REQ_MID, 32'h5A5A_5A5A);
    `CHK("ce_write_ready", 1'h1, wrdy[0])
    ce = 1'h1;
    repeat (4) @(negedge ref_clk);
    `CHK("ce_tx_count", n, i_link.got[0].size())
    test_done;
  end
endmodule

// ===== verification/link_model.sv
`timescale 1ns/1ps
module link_model (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [31:0] tx_req_data_i,
  input  wire logic        tx_req_last_i,
  input  wire logic        tx_req_valid_i,
  output logic             tx_req_ready_o,
  input  wire logic [31:0] tx_rsp_data_i,
  input  wire logic        tx_rsp_last_i,
  input  wire logic        tx_rsp_valid_i,
  output logic             tx_rsp_ready_o,
  output logic [31:0]      rx_req_data_o,
  output logic             rx_req_valid_o,
  input  wire logic        rx_req_ready_i,
  output logic [31:0]      rx_rsp_data_o,
  output logic             rx_rsp_valid_o,
  input  wire logic        rx_rsp_ready_i
);
  logic        stall;
  logic [32:0] got [2][$];

  initial begin
    stall = 1'h0;
    rx_req_valid_o = 1'h0;
    rx_rsp_valid_o = 1'h0;
    rx_req_data_o = 32'h0;
    rx_rsp_data_o = 32'h0;
  end

  // A stall holds every head back, so the queues fill up
  assign tx_req_ready_o = !stall;
  assign tx_rsp_ready_o = !stall;

  // Records each head in the order it left, last flag on top
  always @(posedge ref_clk_i) begin
    if (rst_n_i && tx_req_valid_i && !stall) got[0].push_back({tx_req_last_i, tx_req_data_i});
    if (rst_n_i && tx_rsp_valid_i && !stall) got[1].push_back({tx_rsp_last_i, tx_rsp_data_i});
  end

  // Holds valid and data until ready is seen at a rising edge, then releases
  task automatic push(input bit sel, input logic [31:0] d, output bit ok);
    bit r;
    @(negedge ref_clk_i);
    if (sel) begin
      rx_rsp_data_o = d;
      rx_rsp_valid_o = 1'h1;
    end else begin
      rx_req_data_o = d;
      rx_req_valid_o = 1'h1;
    end
    ok = 1'h0;
    for (int i = 0; i < 50 && !ok; i++) begin
      r = sel ? rx_rsp_ready_i : rx_req_ready_i;
      @(posedge ref_clk_i);
      ok = r;
      if (!ok) @(negedge ref_clk_i);
    end
    @(negedge ref_clk_i);
    // Released data shows the inverse so stale values never pass
    if (sel) begin
      rx_rsp_valid_o = 1'h0;
      rx_rsp_data_o = ~d;
    end else begin
      rx_req_valid_o = 1'h0;
      rx_req_data_o = ~d;
    end
  endtask
endmodule
